// [logic/csr_map.svh]
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH
// System register numbers
`define CSR_N_IRQ_PC     5'h00
`define CSR_N_IRQ_SW     5'h01
`define CSR_N_NMI_PC     5'h02
`define CSR_N_NMI_SW     5'h03
`define CSR_N_ECR        5'h04
`define CSR_N_PSW        5'h05
`define CSR_N_TCL_PC     5'h10
`define CSR_N_TCL_SW     5'h11
`define CSR_N_DBG_PC     5'h12
`define CSR_N_DBG_SW     5'h13
`define CSR_N_TABLE_CALL_BASE_POINTER       5'h14
// Implemented bits
`define CSR_PC_MASK      32'h03ff_ffff
`define CSR_PC_RET_MASK  32'h03ff_fffe
`define CSR_SW_MASK      32'h0000_00ff
`define CSR_PSW_RST      32'h0000_0020
`define CSR_ZERO         32'h0000_0000
`define CSR_PSW_NP_BIT   7
`endif

// [logic/csr_pkg.sv]
`default_nettype none
package csr_pkg;
   typedef logic [31:0] csr_word_t;
   typedef logic [4:0]  csr_num_t;
   // Which saved pair a return reloads from
   typedef enum logic [3:0] {
      CSR_RET_NONE = 4'h1,
      CSR_RET_IRQ  = 4'h2,
      CSR_RET_NMI  = 4'h4,
      CSR_RET_TCL  = 4'h8
   } csr_ret_t;
endpackage
`default_nettype wire

// [logic/csr_save_pair.sv]
`timescale 1ns/100ps
`default_nettype none
`include "csr_map.svh"
// Saved PC plus saved status pair; hardware capture beats software write
module csr_save_pair #(
   parameter csr_pkg::csr_word_t PC_MASK = `CSR_PC_MASK,
   parameter csr_pkg::csr_word_t SW_MASK = `CSR_SW_MASK
) (
   input  wire logic               i_clk_sys,
   input  wire logic               i_nrst,
   input  wire logic               i_cap,
   input  wire csr_pkg::csr_word_t i_cap_pc,
   input  wire csr_pkg::csr_word_t i_cap_sw,
   input  wire logic               i_wr_pc,
   input  wire logic               i_wr_sw,
   input  wire csr_pkg::csr_word_t i_wdata,
   output csr_pkg::csr_word_t      o_pc,
   output csr_pkg::csr_word_t      o_sw
);
   csr_pkg::csr_word_t pc_ff;
   csr_pkg::csr_word_t sw_ff;
   csr_pkg::csr_word_t nxt_pc;
   csr_pkg::csr_word_t nxt_sw;

   always_comb begin
      nxt_pc = pc_ff;
      nxt_sw = sw_ff;
      if (i_cap) begin
         nxt_pc = i_cap_pc & PC_MASK;
         nxt_sw = i_cap_sw & SW_MASK;
      end else begin
         if (i_wr_pc) begin
            nxt_pc = i_wdata & PC_MASK;
         end
         if (i_wr_sw) begin
            nxt_sw = i_wdata & SW_MASK;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         pc_ff <= `CSR_ZERO;
         sw_ff <= `CSR_ZERO;
      end else begin
         pc_ff <= nxt_pc;
         sw_ff <= nxt_sw;
      end
   end

   assign o_pc = pc_ff;
   assign o_sw = sw_ff;
endmodule
`default_nettype wire

// [logic/csr_regfile.sv]
// Functional notes
// RULE_01 - Instruction operand number selects system register
// RULE_02 - Numbers 0-5: irq pair, nmi pair, code, status
// RULE_03 - 16-17 table call, 18-19 debug, 20 base
// RULE_04 - Software avoids reserved numbers 6-15, 21-31
// RULE_05 - Exception code register is read only
// RULE_06 - Debug pair usable only inside debug window
// RULE_07 - Return ignores saved PC bit 0
// RULE_08 - Software writes even saved PC values
// RULE_09 - Irq or exception saves PC and status
// RULE_10 - NMI saves to NMI pair only
// RULE_11 - Saved PC is next instruction address
// RULE_12 - Irq pair reserved bits read zero
// RULE_13 - NMI pair reserved bits read zero
// RULE_14 - Return after irq reloads from irq pair
// RULE_15 - Return after NMI reloads from NMI pair
// RULE_16 - Each event writes its exception code; here only irq and NMI entries load it
// RULE_17 - Software saves irq pair before nesting
// RULE_18 - Every system register is 32 bits
// RULE_19 - PC keeps 26 bits, bit 0 zero; software writes to a saved PC keep bit 0 here
// RULE_20 - Status write effective next; holds off acknowledge
// RULE_21 - Debug pair outside window reads zero, ignores writes
`timescale 1ns/100ps
`default_nettype none
`include "csr_map.svh"
module csr_regfile (
   input  wire logic               i_clk_sys,
   input  wire logic               i_nrst,
   input  wire logic               i_sr_wr,
   input  wire logic               i_sr_rd,
   input  wire csr_pkg::csr_num_t  i_sr_num,
   input  wire csr_pkg::csr_word_t i_sr_wdata,
   input  wire csr_pkg::csr_word_t i_next_pc,
   input  wire logic               i_irq_entry,
   input  wire logic               i_nmi_entry,
   input  wire csr_pkg::csr_word_t i_exc_code,
   input  wire logic               i_tcall_entry,
   input  wire logic               i_dbg_entry,
   input  wire logic               i_return_from_interrupt_instr,
   input  wire logic               i_tcall_ret,
   input  wire logic               i_dbg_ret,
   input  wire logic               i_psw_load,
   input  wire csr_pkg::csr_word_t i_psw_new,
   output csr_pkg::csr_word_t      o_sr_rdata,
   output logic                    o_sr_rvalid,
   output csr_pkg::csr_word_t      o_psw,
   output logic                    o_ack_hold,
   output csr_pkg::csr_word_t      o_tcall_base,
   output logic                    o_dbg_window,
   output logic                    o_ret_valid,
   output csr_pkg::csr_word_t      o_ret_pc,
   output csr_pkg::csr_word_t      o_ret_psw
);
   logic               wr_irq_pc;
   logic               wr_irq_sw;
   logic               wr_nmi_pc;
   logic               wr_nmi_sw;
   logic               wr_psw;
   logic               wr_tcl_pc;
   logic               wr_tcl_sw;
   logic               wr_dbg_pc;
   logic               wr_dbg_sw;
   logic               wr_table_call_base_pointer;
   logic               cap_irq;
   csr_pkg::csr_word_t cur_pc;
   csr_pkg::csr_word_t irq_pc;
   csr_pkg::csr_word_t irq_sw;
   csr_pkg::csr_word_t nmi_pc;
   csr_pkg::csr_word_t nmi_sw;
   csr_pkg::csr_word_t tcl_pc;
   csr_pkg::csr_word_t tcl_sw;
   csr_pkg::csr_word_t dbg_pc;
   csr_pkg::csr_word_t dbg_sw;
   csr_pkg::csr_ret_t  ret_sel;
   csr_pkg::csr_word_t psw_ff;
   csr_pkg::csr_word_t ecr_ff;
   csr_pkg::csr_word_t table_call_base_pointer_ff;
   logic               dbg_win_ff;
   csr_pkg::csr_word_t rdata_ff;
   logic               rvalid_ff;
   logic               ret_valid_ff;
   csr_pkg::csr_word_t ret_pc_ff;
   csr_pkg::csr_word_t ret_psw_ff;
   csr_pkg::csr_word_t nxt_psw;
   csr_pkg::csr_word_t nxt_ecr;
   csr_pkg::csr_word_t nxt_table_call_base_pointer;
   logic               nxt_dbg_win;
   csr_pkg::csr_word_t nxt_rdata;
   logic               nxt_rvalid;
   logic               nxt_ret_valid;
   csr_pkg::csr_word_t nxt_ret_pc;
   csr_pkg::csr_word_t nxt_ret_psw;
   // Write decode from the instruction operand
   always_comb begin
      wr_irq_pc = 1'b0;
      wr_irq_sw = 1'b0;
      wr_nmi_pc = 1'b0;
      wr_nmi_sw = 1'b0;
      wr_psw    = 1'b0;
      wr_tcl_pc = 1'b0;
      wr_tcl_sw = 1'b0;
      wr_dbg_pc = 1'b0;
      wr_dbg_sw = 1'b0;
      wr_table_call_base_pointer   = 1'b0;
      if (i_sr_wr) begin
         case (i_sr_num) // RULE_01
            `CSR_N_IRQ_PC: wr_irq_pc = 1'b1; // RULE_02
            `CSR_N_IRQ_SW: wr_irq_sw = 1'b1;
            `CSR_N_NMI_PC: wr_nmi_pc = 1'b1;
            `CSR_N_NMI_SW: wr_nmi_sw = 1'b1;
            `CSR_N_PSW:    wr_psw    = 1'b1;
            `CSR_N_TCL_PC: wr_tcl_pc = 1'b1; // RULE_03
            `CSR_N_TCL_SW: wr_tcl_sw = 1'b1;
            `CSR_N_DBG_PC: wr_dbg_pc = dbg_win_ff; // RULE_06 RULE_21
            `CSR_N_DBG_SW: wr_dbg_sw = dbg_win_ff; // RULE_06 RULE_21
            `CSR_N_TABLE_CALL_BASE_POINTER:   wr_table_call_base_pointer   = 1'b1;
            default:       wr_table_call_base_pointer   = 1'b0; // RULE_05
         endcase
      end
   end
   // Saved PC is the next instruction address, trimmed to 26 bits with bit 0 cleared
   assign cur_pc  = i_next_pc & `CSR_PC_RET_MASK; // RULE_11 RULE_19
   assign cap_irq = i_irq_entry & ~i_nmi_entry; // RULE_10
   csr_save_pair u_irq (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_cap     (cap_irq), // RULE_09
      .i_cap_pc  (cur_pc),
      .i_cap_sw  (psw_ff),
      .i_wr_pc   (wr_irq_pc),
      .i_wr_sw   (wr_irq_sw),
      .i_wdata   (i_sr_wdata),
      .o_pc      (irq_pc),
      .o_sw      (irq_sw)
   );
   csr_save_pair u_nmi (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_cap     (i_nmi_entry), // RULE_10
      .i_cap_pc  (cur_pc),
      .i_cap_sw  (psw_ff),
      .i_wr_pc   (wr_nmi_pc),
      .i_wr_sw   (wr_nmi_sw),
      .i_wdata   (i_sr_wdata),
      .o_pc      (nmi_pc),
      .o_sw      (nmi_sw)
   );
   csr_save_pair u_tcl (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_cap     (i_tcall_entry),
      .i_cap_pc  (cur_pc),
      .i_cap_sw  (psw_ff),
      .i_wr_pc   (wr_tcl_pc),
      .i_wr_sw   (wr_tcl_sw),
      .i_wdata   (i_sr_wdata),
      .o_pc      (tcl_pc),
      .o_sw      (tcl_sw)
   );
   csr_save_pair u_dbg (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_cap     (i_dbg_entry),
      .i_cap_pc  (cur_pc),
      .i_cap_sw  (psw_ff),
      .i_wr_pc   (wr_dbg_pc),
      .i_wr_sw   (wr_dbg_sw),
      .i_wdata   (i_sr_wdata),
      .o_pc      (dbg_pc),
      .o_sw      (dbg_sw)
   );
   // Return source: NMI pair while the NMI-in-progress flag is set
   always_comb begin
      ret_sel = csr_pkg::CSR_RET_NONE;
      if (i_return_from_interrupt_instr) begin
         if (psw_ff[`CSR_PSW_NP_BIT]) begin
            ret_sel = csr_pkg::CSR_RET_NMI; // RULE_15
         end else begin
            ret_sel = csr_pkg::CSR_RET_IRQ; // RULE_14
         end
      end else if (i_tcall_ret) begin
         ret_sel = csr_pkg::CSR_RET_TCL;
      end
   end
   always_comb begin
      nxt_ret_valid = 1'b0;
      nxt_ret_pc    = ret_pc_ff;
      nxt_ret_psw   = ret_psw_ff;
      case (ret_sel)
         csr_pkg::CSR_RET_IRQ: begin
            nxt_ret_valid = 1'b1;
            nxt_ret_pc    = irq_pc & `CSR_PC_RET_MASK; // RULE_07
            nxt_ret_psw   = irq_sw;
         end
         csr_pkg::CSR_RET_NMI: begin
            nxt_ret_valid = 1'b1;
            nxt_ret_pc    = nmi_pc & `CSR_PC_RET_MASK; // RULE_07
            nxt_ret_psw   = nmi_sw;
         end
         csr_pkg::CSR_RET_TCL: begin
            nxt_ret_valid = 1'b1;
            nxt_ret_pc    = tcl_pc & `CSR_PC_RET_MASK; // RULE_07
            nxt_ret_psw   = tcl_sw;
         end
         default: begin
            if (i_dbg_ret) begin
               nxt_ret_valid = 1'b1;
               nxt_ret_pc    = dbg_pc & `CSR_PC_RET_MASK;
               nxt_ret_psw   = dbg_sw;
            end
         end
      endcase
   end
   // Status word, code register, base pointer and debug window
   always_comb begin
      nxt_psw = psw_ff;
      if (nxt_ret_valid) begin
         nxt_psw = nxt_ret_psw & `CSR_SW_MASK;
      end else if (wr_psw) begin
         nxt_psw = i_sr_wdata & `CSR_SW_MASK; // RULE_20 RULE_18
      end else if (i_psw_load) begin
         nxt_psw = i_psw_new & `CSR_SW_MASK;
      end
      nxt_ecr = ecr_ff;
      if (i_irq_entry | i_nmi_entry) begin
         nxt_ecr = i_exc_code; // RULE_16
      end
      nxt_table_call_base_pointer = wr_table_call_base_pointer ? i_sr_wdata : table_call_base_pointer_ff;
      // Entry beats a return in the same cycle
      nxt_dbg_win = i_dbg_entry | (dbg_win_ff & ~i_dbg_ret); // RULE_06
   end
   // Read mux; reserved numbers and a closed debug window read zero
   always_comb begin
      nxt_rvalid = i_sr_rd;
      nxt_rdata  = `CSR_ZERO;
      if (i_sr_rd) begin
         case (i_sr_num) // RULE_01
            `CSR_N_IRQ_PC: nxt_rdata = irq_pc; // RULE_02 RULE_12
            `CSR_N_IRQ_SW: nxt_rdata = irq_sw; // RULE_12
            `CSR_N_NMI_PC: nxt_rdata = nmi_pc; // RULE_13
            `CSR_N_NMI_SW: nxt_rdata = nmi_sw; // RULE_13
            `CSR_N_ECR:    nxt_rdata = ecr_ff; // RULE_05
            `CSR_N_PSW:    nxt_rdata = psw_ff;
            `CSR_N_TCL_PC: nxt_rdata = tcl_pc; // RULE_03
            `CSR_N_TCL_SW: nxt_rdata = tcl_sw;
            `CSR_N_DBG_PC: nxt_rdata = dbg_win_ff ? dbg_pc : `CSR_ZERO; // RULE_21
            `CSR_N_DBG_SW: nxt_rdata = dbg_win_ff ? dbg_sw : `CSR_ZERO; // RULE_21
            `CSR_N_TABLE_CALL_BASE_POINTER:   nxt_rdata = table_call_base_pointer_ff;
            default:       nxt_rdata = `CSR_ZERO;
         endcase
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         psw_ff       <= `CSR_PSW_RST;
         ecr_ff       <= `CSR_ZERO;
         table_call_base_pointer_ff      <= `CSR_ZERO;
         dbg_win_ff   <= 1'b0;
         rdata_ff     <= `CSR_ZERO;
         rvalid_ff    <= 1'b0;
         ret_valid_ff <= 1'b0;
         ret_pc_ff    <= `CSR_ZERO;
         ret_psw_ff   <= `CSR_ZERO;
      end else begin
         psw_ff       <= nxt_psw;
         ecr_ff       <= nxt_ecr;
         table_call_base_pointer_ff      <= nxt_table_call_base_pointer;
         dbg_win_ff   <= nxt_dbg_win;
         rdata_ff     <= nxt_rdata;
         rvalid_ff    <= nxt_rvalid;
         ret_valid_ff <= nxt_ret_valid;
         ret_pc_ff    <= nxt_ret_pc;
         ret_psw_ff   <= nxt_ret_psw;
      end
   end
   assign o_sr_rdata   = rdata_ff;
   assign o_sr_rvalid  = rvalid_ff;
   assign o_psw        = psw_ff;
   assign o_ack_hold   = wr_psw; // RULE_20
   assign o_tcall_base = table_call_base_pointer_ff;
   assign o_dbg_window = dbg_win_ff;
   assign o_ret_valid  = ret_valid_ff;
   assign o_ret_pc     = ret_pc_ff;
   assign o_ret_psw    = ret_psw_ff;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);

   ecr_read_only_a: assert property ( // RULE_05
      (i_sr_wr && !i_irq_entry && !i_nmi_entry) |=> $stable(ecr_ff))
      else $error("code register changed by a write");
   ecr_capture_a: assert property ( // RULE_16
      (i_irq_entry || i_nmi_entry) |=> ecr_ff == $past(i_exc_code))
      else $error("code not captured on entry");
   irq_capture_a: assert property ( // RULE_09
      cap_irq |=> (irq_pc == ($past(i_next_pc) & `CSR_PC_RET_MASK))
                  && (irq_sw == ($past(psw_ff) & `CSR_SW_MASK)))
      else $error("irq pair not captured");
   nmi_keeps_irq_a: assert property ( // RULE_10
      (i_nmi_entry && !i_sr_wr) |=> $stable(irq_pc) && $stable(irq_sw)
                  && nmi_pc == ($past(i_next_pc) & `CSR_PC_RET_MASK))
      else $error("nmi entry disturbed irq pair");
   irq_reserved_a: assert property ( // RULE_12
      irq_pc[31:26] == 6'h00 && irq_sw[31:8] == 24'h00_0000)
      else $error("irq pair reserved bits set");
   nmi_reserved_a: assert property ( // RULE_13
      nmi_pc[31:26] == 6'h00 && nmi_sw[31:8] == 24'h00_0000)
      else $error("nmi pair reserved bits set");
   return_from_interrupt_instr_irq_a: assert property ( // RULE_14
      (i_return_from_interrupt_instr && !psw_ff[`CSR_PSW_NP_BIT]) |=> o_ret_valid
         && o_ret_pc == ($past(irq_pc) & `CSR_PC_RET_MASK)
         && o_ret_psw == $past(irq_sw))
      else $error("irq return from wrong pair");
   return_from_interrupt_instr_nmi_a: assert property ( // RULE_15
      (i_return_from_interrupt_instr && psw_ff[`CSR_PSW_NP_BIT]) |=> o_ret_valid
         && o_ret_psw == $past(nmi_sw) && o_psw == $past(nmi_sw))
      else $error("nmi return from wrong pair");
   ret_even_a: assert property ( // RULE_07
      o_ret_valid |-> o_ret_pc[0] == 1'b0)
      else $error("return PC odd");
   dbg_closed_a: assert property ( // RULE_21
      (i_sr_rd && !dbg_win_ff && i_sr_num == `CSR_N_DBG_PC)
         ##1 o_sr_rvalid |-> o_sr_rdata == `CSR_ZERO)
      else $error("debug pair visible outside window");
   psw_write_a: assert property ( // RULE_20
      (wr_psw && !nxt_ret_valid) |-> o_ack_hold
         ##1 o_psw == ($past(i_sr_wdata) & `CSR_SW_MASK))
      else $error("status write not taken or not held");

   irq_entry_c:  cover property (cap_irq ##[1:20] i_return_from_interrupt_instr);
   nmi_entry_c:  cover property (i_nmi_entry ##[1:20] i_return_from_interrupt_instr);
   dbg_read_c:   cover property (i_dbg_entry ##[1:10] (i_sr_rd && dbg_win_ff));
   psw_write_c:  cover property (wr_psw ##1 i_irq_entry);
endmodule
`default_nettype wire

// [sim/csr_pipe_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Pipeline and event sequencer standing in front of the register file
module csr_pipe_model (
   input  wire logic          i_clk_sys,
   output csr_pkg::csr_word_t o_next_pc,
   output csr_pkg::csr_word_t o_exc_code,
   output csr_pkg::csr_word_t o_psw_new,
   output logic [7:0]         o_ev
);
   initial begin
      o_next_pc  = 32'h0000_0000;
      o_exc_code = 32'h0000_0000;
      o_psw_new  = 32'h0000_0000;
      o_ev       = 8'h00;
   end

   // Kinds: 0 irq, 1 nmi, 2 table call, 3 debug trap, 4 return,
   // 5 table return, 6 debug return, 7 status load
   task automatic fire(input int kind, input csr_pkg::csr_word_t val,
                       input csr_pkg::csr_word_t code);
      @(posedge i_clk_sys);
      o_next_pc  <= val;
      o_psw_new  <= val;
      o_exc_code <= code;
      o_ev[kind] <= 1'b1;
      @(posedge i_clk_sys);
      o_ev       <= 8'h00;
      // Released values do not linger on the lines
      o_next_pc  <= ~val;
      o_psw_new  <= ~val;
      o_exc_code <= ~code;
   endtask
endmodule
`default_nettype wire

// [sim/csr_regfile_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "csr_map.svh"
module csr_regfile_tb_top;
   logic               clk;
   logic               nrst;
   logic               sr_wr;
   logic               sr_rd;
   csr_pkg::csr_num_t  sr_num;
   csr_pkg::csr_word_t sr_wdata;
   csr_pkg::csr_word_t next_pc;
   csr_pkg::csr_word_t exc_code;
   csr_pkg::csr_word_t psw_new;
   logic [7:0]         ev;
   csr_pkg::csr_word_t rdata;
   csr_pkg::csr_word_t program_status_word;
   csr_pkg::csr_word_t tbase;
   csr_pkg::csr_word_t ret_pc;
   csr_pkg::csr_word_t ret_psw;
   csr_pkg::csr_word_t exp_w;
   logic               rvalid;
   logic               ack_hold;
   logic               dbg_win;
   logic               ret_valid;
   int                 n_mismatch;
   int                 samples_checked;
   csr_pkg::csr_num_t  rst_n[15] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
      5'h05, 5'h06, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1f};
   csr_pkg::csr_num_t  wr_n[10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10,
      5'h11, 5'h04, 5'h12, 5'h07, 5'h05};
   csr_pkg::csr_word_t wr_e[10] = '{32'h03ff_ffff, 32'h0000_00ff,
      32'h03ff_ffff, 32'h0000_00ff, 32'h03ff_ffff, 32'h0000_00ff,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0023};

   csr_pipe_model csr_pipe_model_inst (
      .i_clk_sys  (clk),
      .o_next_pc  (next_pc),
      .o_exc_code (exc_code),
      .o_psw_new  (psw_new),
      .o_ev       (ev)
   );

   csr_regfile csr_regfile_inst (
      .i_clk_sys     (clk),
      .i_nrst        (nrst),
      .i_sr_wr       (sr_wr),
      .i_sr_rd       (sr_rd),
      .i_sr_num      (sr_num),
      .i_sr_wdata    (sr_wdata),
      .i_next_pc     (next_pc),
      .i_irq_entry   (ev[0]),
      .i_nmi_entry   (ev[1]),
      .i_exc_code    (exc_code),
      .i_tcall_entry (ev[2]),
      .i_dbg_entry   (ev[3]),
      .i_return_from_interrupt_instr        (ev[4]),
      .i_tcall_ret   (ev[5]),
      .i_dbg_ret     (ev[6]),
      .i_psw_load    (ev[7]),
      .i_psw_new     (psw_new),
      .o_sr_rdata    (rdata),
      .o_sr_rvalid   (rvalid),
      .o_psw         (program_status_word),
      .o_ack_hold    (ack_hold),
      .o_tcall_base  (tbase),
      .o_dbg_window  (dbg_win),
      .o_ret_valid   (ret_valid),
      .o_ret_pc      (ret_pc),
      .o_ret_psw     (ret_psw)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk_word(input csr_pkg::csr_word_t got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic sr_write(input csr_pkg::csr_num_t n,
                           input csr_pkg::csr_word_t d);
      @(posedge clk);
      sr_wr    <= 1'b1;
      sr_num   <= n;
      sr_wdata <= d;
      #1 chk_bit(ack_hold, n == `CSR_N_PSW);
      @(posedge clk);
      sr_wr    <= 1'b0;
      sr_wdata <= ~d;
   endtask

   task automatic sr_read(input csr_pkg::csr_num_t n,
                          input csr_pkg::csr_word_t exp);
      @(posedge clk);
      sr_rd  <= 1'b1;
      sr_num <= n;
      @(posedge clk);
      sr_rd  <= 1'b0;
      #1;
      chk_bit(rvalid, 1'b1);
      chk_word(rdata, exp);
      @(posedge clk);
      #1;
      chk_bit(rvalid, 1'b0);
      chk_word(rdata, `CSR_ZERO);
   endtask

   task automatic ret_chk(input int kind, input csr_pkg::csr_word_t pc, ps);
      csr_pipe_model_inst.fire(kind, 32'h0000_0000, 32'h0000_0000);
      #1;
      chk_bit(ret_valid, 1'b1);
      chk_word(ret_pc, pc);
      chk_word(ret_psw, ps);
      chk_word(program_status_word, ps);
   endtask

   task automatic results();
      $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      results();
   end

   initial begin
      n_mismatch      = 0;
      samples_checked = 0;
      nrst     = 1'b0;
      sr_wr    = 1'b0;
      sr_rd    = 1'b0;
      sr_num   = 5'h00;
      sr_wdata = 32'h0000_0000;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 15; i++) begin
         exp_w = (rst_n[i] == `CSR_N_PSW) ? `CSR_PSW_RST : `CSR_ZERO;
         sr_read(rst_n[i], exp_w);
      end
      chk_bit(dbg_win, 1'b0);
      $display("test reset done");
      for (int i = 0; i < 9; i++)
         sr_write(wr_n[i], 32'hffff_ffff);
      sr_write(5'h14, 32'h1234_5678);
      sr_write(5'h05, 32'h0000_0123);
      for (int i = 0; i < 10; i++)
         sr_read(wr_n[i], wr_e[i]);
      sr_read(5'h14, 32'h1234_5678);
      chk_word(tbase, 32'h1234_5678);
      $display("test access done");
      csr_pipe_model_inst.fire(0, 32'hfc00_0003, 32'h0000_0021);
      sr_read(5'h00, 32'h0000_0002);
      sr_read(5'h01, 32'h0000_0023);
      sr_read(5'h04, 32'h0000_0021);
      sr_read(5'h02, 32'h03ff_ffff);
      csr_pipe_model_inst.fire(1, 32'h0123_4567, 32'h0000_0010);
      sr_read(5'h02, 32'h0123_4566);
      sr_read(5'h03, 32'h0000_0023);
      sr_read(5'h00, 32'h0000_0002);
      sr_read(5'h04, 32'h0000_0010);
      $display("test entry done");
      sr_write(5'h00, 32'h0000_1235);
      sr_write(5'h01, 32'h0000_01a5);
      ret_chk(4, 32'h0000_1234, 32'h0000_00a5);
      ret_chk(4, 32'h0123_4566, 32'h0000_0023);
      $display("test return done");
      csr_pipe_model_inst.fire(2, 32'h0000_0101, 32'h0000_0000);
      sr_read(5'h10, 32'h0000_0100);
      sr_read(5'h11, 32'h0000_0023);
      ret_chk(5, 32'h0000_0100, 32'h0000_0023);
      $display("test table call done");
      csr_pipe_model_inst.fire(3, 32'h0000_2223, 32'h0000_0000);
      #1;
      chk_bit(dbg_win, 1'b1);
      sr_read(5'h12, 32'h0000_2222);
      sr_write(5'h13, 32'h0000_01ff);
      sr_read(5'h13, 32'h0000_00ff);
      ret_chk(6, 32'h0000_2222, 32'h0000_00ff);
      chk_bit(dbg_win, 1'b0);
      sr_read(5'h12, 32'h0000_0000);
      $display("test debug done");
      csr_pipe_model_inst.fire(7, 32'hffff_ff5a, 32'h0000_0000);
      sr_read(5'h05, 32'h0000_005a);
      $display("test status load done");
      sr_write(5'h10, 32'h0000_0200);
      sr_read(5'h10, 32'h0000_0200);
      ret_chk(5, 32'h0000_0200, 32'h0000_0023);
      $display("test even pc done");
      results();
   end
endmodule
`default_nettype wire
